// file: core/line_presence_map.vh
// Constants for the line presence supervisor: register offsets,
// field positions, reset values and timing figures.
// Assumes a Wishbone classic slave with 32-bit data and byte addresses.
`ifndef LINE_PRESENCE_MAP_VH
`define LINE_PRESENCE_MAP_VH

// Register byte offsets
`define LP_CTRL_ADDR        5'h00
`define LP_STATUS_ADDR      5'h04
`define LP_EVT_ADDR         5'h08
`define LP_EVT_CLR_ADDR     5'h0C
`define LP_EVT_EN_ADDR      5'h10
`define LP_ADDR_W           5

// Control register fields
`define LP_CTRL_OFF_BIT     16
`define LP_CTRL_DLY_W       7
`define LP_CTRL_RST_DLY     7'h1E
`define LP_CTRL_RST_OFF     1'b0
`define LP_DLY_MAX          7'h64

// Status and event bit positions
`define LP_ST_ALARM         0
`define LP_ST_FAULT         1
`define LP_ST_READY         2
`define LP_ST_TIMING        3
`define LP_ST_LINE          4
`define LP_EV_ALARM         0
`define LP_EV_FAULT         1
`define LP_EV_W             2

// Timing: delay steps of 100 ms, clock of 50 MHz
`define LP_STEP_MS          100
`define LP_CLK_KHZ          50000
`define LP_STEP_CYC         (`LP_STEP_MS * `LP_CLK_KHZ)

`endif

// file: core/step_divider.v
// Tick divider: one-cycle enable pulse every PERIOD clocks.
// Assumes one clock, synchronous active-high reset; clr restarts count.
`timescale 1ns/10ps
module step_divider #(
    parameter PERIOD = 5000000
) (
    input  wire clk_i,
    input  wire rst_i,
    input  wire clr_i,
    output wire tick_o
);
    reg [22:0] cnt_r;

    // Count down, reload at zero
    always @(posedge clk_i) begin
        if (rst_i || clr_i || cnt_r == 23'h00_0000) begin
            cnt_r <= PERIOD[22:0] - 23'h00_0001;
        end else begin
            cnt_r <= cnt_r - 23'h00_0001;
        end
    end

    assign tick_o = (cnt_r == 23'h00_0000) && !clr_i;
endmodule // step_divider

// file: core/line_presence_supervisor.v
// Line presence supervisor for a medium-voltage motor starter.
// Assumes line_detect_i is an asynchronous pin and start_cmd_i a pin.
// What this block does; [R9] falls to the installer
// [R1] Delay setting is off or 0 to 10.0 s; reset value 3.0 s.
// [R2] Delay setting governs warning, fault and ready outputs together.
// [R3] Off: missing line while stopped counts as abnormal.
// [R4] Off: missing line asserts the no-line alarm.
// [R5] Off: missing line drops the ready condition.
// [R6] Off: start while line missing raises the no-line fault.
// [R7] Delay set: missing line while stopped gives no alarm, ready stays.
// [R8] Delay set: fault if line stays missing for the whole delay.
// [R9] Installer assigns a relay to the run function for the contactor.
// [R10] Timer starts on start, counts while line missing, stops on line.
//
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/10ps
`include "line_presence_map.vh"
module line_presence_supervisor #(
    parameter STEP_CYC = `LP_STEP_CYC
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [4:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    input  wire        line_detect_i,
    input  wire        start_cmd_i,
    input  wire        fault_reset_i,
    output reg         alarm_o,
    output reg         fault_o,
    output reg         ready_o,
    output reg  [7:0]  no_line_fault_code_o,
    output wire        irq_o
);
    localparam ST_IDLE   = 3'b001;
    localparam ST_TIMING = 3'b010;
    localparam ST_FAULT  = 3'b100;

    reg [1:0]  line_sync_r;
    reg [1:0]  start_sync_r;
    reg [1:0]  frst_sync_r;
    reg        start_d_r;
    reg        dly_off_r;
    reg [6:0]  dly_r;
    reg [6:0]  steps_r;
    reg [2:0]  state_r;
    reg [2:0]  state_nxt;
    reg [1:0]  evt_r;
    reg [1:0]  evt_en_r;
    reg        alarm_d_r;
    wire       line_ok;
    wire       start_pulse;
    wire       tick;
    wire       bus_req;
    wire       wr_ok;
    wire [1:0] evt_set;
    wire [1:0] evt_clr;

    // Two-stage synchronisers for pin inputs
    always @(posedge clk_i) begin
        if (rst_i) begin
            line_sync_r  <= 2'h0;
            start_sync_r <= 2'h0;
            frst_sync_r  <= 2'h0;
            start_d_r    <= 1'b0;
        end else begin
            line_sync_r  <= {line_sync_r[0], line_detect_i};
            start_sync_r <= {start_sync_r[0], start_cmd_i};
            frst_sync_r  <= {frst_sync_r[0], fault_reset_i};
            start_d_r    <= start_sync_r[1];
        end
    end

    assign line_ok     = line_sync_r[1];
    assign start_pulse = start_sync_r[1] && !start_d_r;

    // Bus request decode; one-cycle ack after request
    assign bus_req = cyc_i && stb_i && !ack_o;
    assign wr_ok   = bus_req && we_i;

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= bus_req;
        end
    end

    // Control register: delay in 100 ms steps and off flag
    always @(posedge clk_i) begin
        if (rst_i) begin
            dly_r     <= `LP_CTRL_RST_DLY;                  // see [R1]
            dly_off_r <= `LP_CTRL_RST_OFF;
        end else if (wr_ok && adr_i == `LP_CTRL_ADDR) begin
            if (sel_i[0]) begin
                // Values above 10.0 s clamp to the limit
                dly_r <= (dat_i[6:0] > `LP_DLY_MAX) ?
                         `LP_DLY_MAX : dat_i[6:0];          // see [R1]
            end
            if (sel_i[2]) begin
                dly_off_r <= dat_i[`LP_CTRL_OFF_BIT];       // see [R1]
            end
        end
    end

    // Interrupt enable register
    always @(posedge clk_i) begin
        if (rst_i) begin
            evt_en_r <= 2'h0;
        end else if (wr_ok && adr_i == `LP_EVT_EN_ADDR && sel_i[0]) begin
            evt_en_r <= dat_i[1:0];
        end
    end

    // Delay step divider, restarted when timing begins
    step_divider #(
        .PERIOD (STEP_CYC)
    ) u_step (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .clr_i  (state_r != ST_TIMING),
        .tick_o (tick)
    );

    // Supervision state machine
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (start_pulse && !line_ok) begin
                    if (dly_off_r) begin
                        state_nxt = ST_FAULT;               // see [R6]
                    end else if (dly_r == 7'h00) begin
                        state_nxt = ST_FAULT;               // see [R8]
                    end else begin
                        state_nxt = ST_TIMING;              // see [R10]
                    end
                end
            end
            ST_TIMING: begin
                if (line_ok) begin
                    state_nxt = ST_IDLE;                    // see [R10]
                end else if (tick && steps_r + 7'h01 >= dly_r) begin
                    state_nxt = ST_FAULT;                   // see [R8]
                end
            end
            ST_FAULT: begin
                if (frst_sync_r[1]) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // State and elapsed step counter
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            steps_r <= 7'h00;
        end else begin
            state_r <= state_nxt;
            if (state_r != ST_TIMING) begin
                steps_r <= 7'h00;
            end else if (tick && !line_ok) begin
                steps_r <= steps_r + 7'h01;                 // see [R10]
            end
        end
    end

    // Outputs, all governed by the delay setting
    always @(posedge clk_i) begin
        if (rst_i) begin
            alarm_o            <= 1'b0;
            fault_o            <= 1'b0;
            ready_o            <= 1'b0;
            no_line_fault_code_o <= 8'h00;
            alarm_d_r          <= 1'b0;
        end else begin
            alarm_o   <= dly_off_r && !line_ok;             // see [R2] [R3] [R4] [R7]
            ready_o   <= !(dly_off_r && !line_ok)
                         && state_nxt != ST_FAULT;          // see [R2] [R5] [R7]
            fault_o   <= (state_nxt == ST_FAULT);           // see [R2] [R6] [R8]
            no_line_fault_code_o <= (state_nxt == ST_FAULT) ?
                                    8'h01 : 8'h00;
            alarm_d_r <= alarm_o;
        end
    end

    // Sticky events: set wins over clear
    assign evt_set = {fault_o == 1'b0 && state_nxt == ST_FAULT,
                      alarm_o && !alarm_d_r};
    assign evt_clr = (wr_ok && adr_i == `LP_EVT_CLR_ADDR && sel_i[0]) ?
                     dat_i[1:0] : 2'h0;

    always @(posedge clk_i) begin
        if (rst_i) begin
            evt_r <= 2'h0;
        end else begin
            evt_r <= (evt_r & ~evt_clr) | evt_set;
        end
    end

    assign irq_o = |(evt_r & evt_en_r);

    // Read data mux; unmapped and clear register read zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (bus_req && !we_i) begin
            case (adr_i)
                `LP_CTRL_ADDR:
                    dat_o <= {15'h0000, dly_off_r, 9'h000, dly_r};
                `LP_STATUS_ADDR:
                    dat_o <= {27'h000_0000, line_ok,
                              state_r == ST_TIMING, ready_o,
                              fault_o, alarm_o};
                `LP_EVT_ADDR:
                    dat_o <= {30'h0000_0000, evt_r};
                `LP_EVT_EN_ADDR:
                    dat_o <= {30'h0000_0000, evt_en_r};
                default:
                    dat_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule // line_presence_supervisor

// file: verification/lps_checker_assertions.sv
// Checker for the supervisor bus handshake and output relations.
// Assumes it is bound onto the supervisor top module.
`timescale 1ns/10ps
module lps_checker (
    input wire       clk_i,
    input wire       rst_i,
    input wire       cyc_i,
    input wire       stb_i,
    input wire       ack_o,
    input wire       line_detect_i,
    input wire       fault_reset_i,
    input wire       alarm_o,
    input wire       fault_o,
    input wire       ready_o,
    input wire [7:0] no_line_fault_code_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Line held up, fault reset held off
    sequence s_line_up; line_detect_i [*6]; endsequence
    sequence s_quiet; !fault_reset_i [*5]; endsequence
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("no ack");
    a_ack_once: assert property (ack_o |=> !ack_o)
        else $error("long ack");
    a_fault_code: assert property (
        no_line_fault_code_o == {7'h00, fault_o}) else $error("bad code");
    a_fault_ready: assert property (fault_o |-> !ready_o)
        else $error("ready in fault");
    a_alarm_ready: assert property (alarm_o |-> !ready_o)
        else $error("ready in alarm");
    a_fault_held: assert property (
        s_quiet ##0 $past(fault_o) |-> fault_o) else $error("fault lost");
    a_line_alarm: assert property (s_line_up |-> !alarm_o)
        else $error("alarm with line");
    a_line_fault: assert property (s_line_up |-> !$rose(fault_o))
        else $error("fault with line");
endmodule // lps_checker
bind line_presence_supervisor lps_checker i_lps_checker (.*);

// file: verification/line_source.sv
// Line source model: upstream supply and an optional inline contactor.
// Assumes the run relay follows the start command.
`timescale 1ns/10ps
module line_source #(
    parameter CLOSE_CYC = 20
) (
    input  wire clk_i,
    input  wire supply_i,
    input  wire inline_i,
    input  wire run_i,
    output wire line_o
);
    integer cnt_r = 0;
    // Run relay closes the contactor after a pickup time
    always @(posedge clk_i) begin
        cnt_r <= run_i ? (cnt_r < CLOSE_CYC ? cnt_r + 1 : cnt_r) : 0;
    end
    assign line_o = supply_i && (!inline_i || cnt_r == CLOSE_CYC);
endmodule // line_source

// file: verification/line_presence_supervisor_tb.sv
// Testbench: supervisor, line source model, bus tasks and scenarios.
// Assumes STEP_CYC of 10, so one delay step is 10 clocks.
`timescale 1ns/10ps
module line_presence_supervisor_tb;
    reg         clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    reg  [4:0]  adr_i = 0;
    reg  [31:0] dat_i = 0, rd;
    reg         fault_reset_i = 0, start_cmd_i = 0, supply = 1, inln = 0;
    wire [31:0] dat_o;
    wire [7:0]  code;
    wire        ack_o, alarm_o, fault_o, ready_o, irq_o, line;
    integer     error_cnt = 0, comparisons = 0, n;
    always #10 clk_i = ~clk_i;
    line_presence_supervisor #(.STEP_CYC(10)) i_line_presence_supervisor (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .line_detect_i(line),
        .start_cmd_i(start_cmd_i), .fault_reset_i(fault_reset_i),
        .alarm_o(alarm_o), .fault_o(fault_o), .ready_o(ready_o),
        .no_line_fault_code_o(code), .irq_o(irq_o));
    line_source i_line_source (.clk_i(clk_i), .supply_i(supply),
        .inline_i(inln), .run_i(start_cmd_i), .line_o(line));
    task conclude;
        begin
            if (error_cnt == 0 && comparisons > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("BAD %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // One classic cycle, held until ack
    task bus(input w, input [4:0] a, input [31:0] d);
        begin
            cyc_i <= 1;
            stb_i <= 1;
            we_i <= w;
            adr_i <= a;
            dat_i <= d;
            n = 0;
            do begin
                @(posedge clk_i);
                n = n + 1;
            end while (ack_o !== 1'b1 && n < 20);
            if (ack_o !== 1'b1) begin
                chk(ack_o, 1);
                conclude;
            end
            rd = dat_o;
            cyc_i <= 0;
            stb_i <= 0;
            @(posedge clk_i);
            if (ack_o !== 1'b0) begin
                chk(ack_o, 0);
                conclude;
            end
        end
    endtask
    task clr_fault;
        begin
            start_cmd_i <= 0;
            fault_reset_i <= 1;
            repeat (6) @(posedge clk_i);
            fault_reset_i <= 0;
            repeat (6) @(posedge clk_i);
        end
    endtask
    task t_regs;
        begin
            bus(0, 5'h00, 0);
            chk(rd, 32'h0000_001E);
            bus(0, 5'h04, 0);
            chk(rd, 32'h0000_0014);
            bus(0, 5'h14, 0);
            chk(rd, 0);
            bus(1, 5'h00, 32'h0000_007F);
            bus(0, 5'h00, 0);
            chk(rd, 32'h0000_0064);
        end
    endtask
    task t_off;
        begin
            bus(1, 5'h00, 32'h0001_001E);
            supply <= 0;
            repeat (8) @(posedge clk_i);
            chk({alarm_o, ready_o}, 2'b10);
            start_cmd_i <= 1;
            repeat (8) @(posedge clk_i);
            chk({fault_o, ready_o, code}, 10'h201);
            chk(irq_o, 0);
            bus(0, 5'h08, 0);
            chk(rd, 3);
            bus(1, 5'h10, 3);
            chk(irq_o, 1);
            bus(1, 5'h0C, 3);
            chk(irq_o, 0);
            supply <= 1;
            clr_fault;
            chk({alarm_o, fault_o, ready_o}, 3'b001);
        end
    endtask
    task t_delay;
        begin
            bus(1, 5'h00, 5);
            supply <= 0;
            repeat (8) @(posedge clk_i);
            chk({alarm_o, ready_o}, 2'b01);
            start_cmd_i <= 1;
            // No fault before 5 steps of 10 clocks have passed
            repeat (50) @(posedge clk_i);
            chk(fault_o, 0);
            n = 0;
            while (fault_o !== 1'b1 && n < 40) begin
                @(posedge clk_i);
                n = n + 1;
            end
            chk({fault_o, ready_o}, 2'b10);
            chk(n < 8, 1);
            if (n == 40) conclude;
            supply <= 1;
            inln <= 1;
            clr_fault;
            start_cmd_i <= 1;
            repeat (90) @(posedge clk_i);
            chk({fault_o, line}, 2'b01);
        end
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        t_regs;
        t_off;
        t_delay;
        conclude;
    end
endmodule // line_presence_supervisor_tb
